/* logic/scp_params.svh */
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH
// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define SCP_ADDR_CMD 8'h00
`define SCP_ADDR_STATUS 8'h04
`define SCP_ADDR_LABEL_IN 8'h08
`define SCP_ADDR_RESP 8'h0c
`define SCP_ADDR_IRQ_STAT 8'h10
`define SCP_ADDR_IRQ_CLR 8'h14
`define SCP_ADDR_IRQ_EN 8'h18
`define SCP_ADDR_LABEL_LEN 8'h1c
// ----------------------------------------------------------------
// command codes, written to cmd[3:0]; argument in cmd[7:4]
// ----------------------------------------------------------------
`define SCP_CMD_GET_TYPE 4'h1
`define SCP_CMD_SET_TYPE 4'h2
`define SCP_CMD_GET_LABEL 4'h3
`define SCP_CMD_SET_LABEL 4'h4
`define SCP_CMD_GET_SERIAL 4'h5
`define SCP_CMD_GET_FW 4'h6
`define SCP_CMD_GET_PORTS 4'h7
`define SCP_CMD_CALL_RESET 4'h8
`define SCP_CMD_CALL_DEFAULTS 4'h9
`define SCP_RESET_ARG 4'h1
// ----------------------------------------------------------------
// field positions, sizes and characters
// ----------------------------------------------------------------
`define SCP_LABEL_START_BIT 8
`define SCP_IRQ_DONE 0
`define SCP_IRQ_TRUNC 1
`define SCP_IRQ_BUSY 2
`define SCP_IRQ_W 3
`define SCP_LABEL_MAX 7'h27
`define SCP_NPORT 4
`define SCP_PORT_CHARS 5
`define SCP_PORT_BODY 7'h17
`define SCP_TYPE_LEN 7'h0c
`define SCP_SERIAL_LEN 7'h08
`define SCP_FW_LEN 7'h06
`define SCP_RESP_DEPTH 128
`define SCP_CH_CR 8'h0d
`define SCP_CH_LF 8'h0a
`define SCP_CH_SPACE 8'h20
`define SCP_CH_ESC 8'h5c
`define SCP_CH_SEMI 8'h3b
`define SCP_CH_ZERO 8'h30
`endif

/* logic/scp_pkg.sv */
package scp_pkg;
  // response builder states
  typedef enum logic [2:0] {ST_IDLE, ST_PFX, ST_BODY, ST_CR, ST_LF} scp_state_t;
  // kind of response line being built
  typedef enum logic [2:0] {K_TYPE, K_SERIAL, K_FW, K_LABEL, K_PORTS, K_PERR, K_MERR} scp_kind_t;
  // status of one video input
  typedef struct packed {
    logic muted;
    logic locked;
    logic [1:0] audio;
    logic [1:0] prot;
    logic [1:0] sig;
    logic [1:0] conn;
  } scp_port_t;
endpackage : scp_pkg

/* logic/scp_top.sv */
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`include "scp_params.svh"
// Operation
// RULE1: type name read-only, set attempts answered with error
// RULE2: label ascii only, truncated to 39 characters
// RULE3: serial and firmware answered as read-only
// RULE4: reset with argument 1 restarts, drops links silently
// RULE5: defaults call restores, restarts, drops, no reply
// RULE6: five characters per input in status list
// RULE7: letter followed by four hex characters
// RULE8: letter T L M U from mute and lock
// RULE9: first status byte always zero
// RULE10: second byte audio, protection, signal, cable
// RULE11: two-bit codes unknown, reserved, absent, present
// RULE12: inputs in port order, semicolon separated
// RULE13: every line ends carriage return line feed
// RULE14: each line starts with two-character type prefix
// RULE15: control characters escaped with backslash
module scp_top #(
  parameter logic [8*12-1:0] TYPE_NAME = "VIDEO-EXT-01", // arbitrary value
  parameter logic [8*8-1:0] SERIAL_NUM = "11223344", // arbitrary value
  parameter logic [8*6-1:0] FW_VERSION = "0.9.1a" // arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire scp_pkg::scp_port_t [`SCP_NPORT-1:0] port_state,
  output logic restart_req,
  output logic restore_req,
  output logic drop_conns,
  output logic irq
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // one nibble as upper-case hex ascii
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_char

  // characters with protocol meaning inside a value
  function automatic logic is_ctrl(input logic [7:0] c);
    is_ctrl = (c == 8'h5c) || (c == 8'h28) || (c == 8'h29) || (c == 8'h2c) ||
              (c == 8'h3b) || (c == 8'h3d) || (c == 8'h23);
  endfunction : is_ctrl

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup; // setup phase
  logic wr_acc; // write takes effect
  logic rd_acc; // read completes
  logic cmd_go; // command register written
  assign setup = psel & ~penable;
  assign wr_acc = psel & penable & pwrite;
  assign rd_acc = psel & penable & ~pwrite;
  assign cmd_go = wr_acc && (paddr == `SCP_ADDR_CMD);
  assign pready = psel & penable; // zero wait states

  // ----------------------------------------------------------------
  // label store
  // ----------------------------------------------------------------
  logic [7:0] label_mem [0:38]; // stored label characters
  logic [6:0] lbl_len_r, lbl_len_nxt; // stored length
  logic lbl_esc_r, lbl_esc_nxt; // backslash seen, next is literal
  logic lbl_we; // store one character
  logic trunc_ev; // character dropped past the limit
  logic clear_label; // defaults restore empties the label
  logic [7:0] lbl_ch; // incoming character
  assign lbl_ch = pwdata[7:0];

  // next label state from writes to the label input register
  always_comb
  begin
    lbl_len_nxt = lbl_len_r;
    lbl_esc_nxt = lbl_esc_r;
    lbl_we = 1'b0;
    trunc_ev = 1'b0;
    if (clear_label)
    begin
      lbl_len_nxt = 7'h00;
      lbl_esc_nxt = 1'b0;
    end
    else if (wr_acc && (paddr == `SCP_ADDR_LABEL_IN))
    begin
      if (pwdata[`SCP_LABEL_START_BIT])
      begin
        // start a fresh label
        lbl_len_nxt = 7'h00;
        lbl_esc_nxt = 1'b0;
      end
      else if (lbl_ch[7])
      begin
        // non-ascii ignored, see RULE2
      end
      else if (!lbl_esc_r && (lbl_ch == `SCP_CH_ESC))
        lbl_esc_nxt = 1'b1; // escaped char follows, see RULE15
      else if (lbl_len_r < `SCP_LABEL_MAX)
      begin
        lbl_we = 1'b1; // stored literally, see RULE15
        lbl_len_nxt = lbl_len_r + 7'h01;
        lbl_esc_nxt = 1'b0;
      end
      else
      begin
        trunc_ev = 1'b1; // beyond 39 dropped, see RULE2
        lbl_esc_nxt = 1'b0;
      end
    end
  end

  // label registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      lbl_len_r <= 7'h00;
      lbl_esc_r <= 1'b0;
    end
    else
    begin
      lbl_len_r <= lbl_len_nxt;
      lbl_esc_r <= lbl_esc_nxt;
    end
  end

  // label memory, no reset needed
  always_ff @(posedge pclk)
  begin
    if (lbl_we)
      label_mem[lbl_len_r[5:0]] <= lbl_ch;
  end

  // ----------------------------------------------------------------
  // response builder
  // ----------------------------------------------------------------
  scp_pkg::scp_state_t st_r, st_nxt; // builder state
  scp_pkg::scp_kind_t kind_r, kind_nxt; // kind of line
  scp_pkg::scp_port_t [`SCP_NPORT-1:0] snap_r, snap_nxt; // inputs at command
  logic [7:0] resp_mem [0:`SCP_RESP_DEPTH-1]; // built line
  logic [6:0] src_r, src_nxt; // body index
  logic [6:0] dst_r, dst_nxt; // write index
  logic [6:0] rd_r, rd_nxt; // read index
  logic [6:0] len_r, len_nxt; // finished line length
  logic esc_r, esc_nxt; // backslash already emitted
  logic rst_r, rst_nxt; // restart pulse
  logic def_r, def_nxt; // defaults pulse
  logic wr_en; // write char to line
  logic [7:0] wr_char; // char to write
  logic [6:0] blen; // body length
  logic [7:0] bchar; // body char at src
  logic [7:0] pfx0, pfx1; // line prefix
  logic done_ev, busy_ev; // events
  logic avail; // unread characters
  integer p, pos; // port and position within port field
  scp_pkg::scp_port_t ps; // port being printed
  logic [7:0] byte2; // second status byte
  assign avail = rd_r < len_r;
  assign clear_label = def_r;

  // body length and character per kind
  always_comb
  begin
    p = int'(src_r) / 6;
    pos = int'(src_r) % 6;
    ps = snap_r[p % `SCP_NPORT];
    byte2 = {ps.audio, ps.prot, ps.sig, ps.conn}; // see RULE10 RULE11
    blen = 7'h00;
    bchar = 8'h00;
    pfx0 = 8'h70; // p
    pfx1 = 8'h72; // r, see RULE3
    unique case (kind_r)
      scp_pkg::K_TYPE:
      begin
        blen = `SCP_TYPE_LEN;
        bchar = TYPE_NAME[(int'(`SCP_TYPE_LEN) - 1 - int'(src_r)) * 8 +: 8];
      end
      scp_pkg::K_SERIAL:
      begin
        blen = `SCP_SERIAL_LEN; // see RULE3
        bchar = SERIAL_NUM[(int'(`SCP_SERIAL_LEN) - 1 - int'(src_r)) * 8 +: 8];
      end
      scp_pkg::K_FW:
      begin
        blen = `SCP_FW_LEN; // see RULE3
        bchar = FW_VERSION[(int'(`SCP_FW_LEN) - 1 - int'(src_r)) * 8 +: 8];
      end
      scp_pkg::K_LABEL:
      begin
        blen = lbl_len_r;
        bchar = label_mem[src_r[5:0] % 6'h27];
        pfx1 = 8'h77; // w, read-write property
      end
      scp_pkg::K_PORTS:
      begin
        blen = `SCP_PORT_BODY; // see RULE6 RULE12
        unique case (pos)
          0: bchar = ps.muted ? (ps.locked ? 8'h55 : 8'h4d)
                              : (ps.locked ? 8'h4c : 8'h54); // see RULE8
          1, 2: bchar = `SCP_CH_ZERO; // see RULE9
          3: bchar = hex_char(byte2[7:4]); // see RULE7
          4: bchar = hex_char(byte2[3:0]); // see RULE7
          default: bchar = `SCP_CH_SEMI; // see RULE12
        endcase
      end
      scp_pkg::K_PERR:
        pfx1 = 8'h45; // pE, see RULE1
      scp_pkg::K_MERR:
      begin
        pfx0 = 8'h6d;
        pfx1 = 8'h45; // mE
      end
    endcase
  end

  // next builder state
  always_comb
  begin
    st_nxt = st_r;
    kind_nxt = kind_r;
    snap_nxt = snap_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    rd_nxt = rd_r;
    len_nxt = len_r;
    esc_nxt = esc_r;
    rst_nxt = 1'b0;
    def_nxt = 1'b0;
    wr_en = 1'b0;
    wr_char = 8'h00;
    done_ev = 1'b0;
    busy_ev = cmd_go && (st_r != scp_pkg::ST_IDLE);
    if (rd_acc && (paddr == `SCP_ADDR_RESP) && avail)
      rd_nxt = rd_r + 7'h01; // pop one character
    unique case (st_r)
      scp_pkg::ST_IDLE:
        if (cmd_go)
        begin
          // a new command discards any unread line
          src_nxt = 7'h00;
          dst_nxt = 7'h00;
          rd_nxt = 7'h00;
          len_nxt = 7'h00;
          esc_nxt = 1'b0;
          snap_nxt = port_state;
          st_nxt = scp_pkg::ST_PFX;
          case (pwdata[3:0])
            `SCP_CMD_GET_TYPE: kind_nxt = scp_pkg::K_TYPE;
            `SCP_CMD_SET_TYPE: kind_nxt = scp_pkg::K_PERR; // see RULE1
            `SCP_CMD_GET_LABEL, `SCP_CMD_SET_LABEL: kind_nxt = scp_pkg::K_LABEL;
            `SCP_CMD_GET_SERIAL: kind_nxt = scp_pkg::K_SERIAL; // see RULE3
            `SCP_CMD_GET_FW: kind_nxt = scp_pkg::K_FW; // see RULE3
            `SCP_CMD_GET_PORTS: kind_nxt = scp_pkg::K_PORTS;
            `SCP_CMD_CALL_RESET:
              if (pwdata[7:4] == `SCP_RESET_ARG)
              begin
                rst_nxt = 1'b1; // silent restart, see RULE4
                st_nxt = scp_pkg::ST_IDLE;
              end
              else
                kind_nxt = scp_pkg::K_MERR;
            `SCP_CMD_CALL_DEFAULTS:
            begin
              def_nxt = 1'b1; // see RULE5
              rst_nxt = 1'b1;
              st_nxt = scp_pkg::ST_IDLE;
            end
            default: kind_nxt = scp_pkg::K_MERR;
          endcase
        end
      scp_pkg::ST_PFX:
      begin
        // two prefix characters and a space, see RULE14
        wr_en = 1'b1;
        wr_char = (src_r == 7'h00) ? pfx0 : ((src_r == 7'h01) ? pfx1 : `SCP_CH_SPACE);
        src_nxt = src_r + 7'h01;
        if (src_r == 7'h02)
        begin
          src_nxt = 7'h00;
          st_nxt = (blen == 7'h00) ? scp_pkg::ST_CR : scp_pkg::ST_BODY;
        end
      end
      scp_pkg::ST_BODY:
      begin
        wr_en = 1'b1;
        if ((kind_r == scp_pkg::K_LABEL) && is_ctrl(bchar) && !esc_r)
        begin
          wr_char = `SCP_CH_ESC; // see RULE15
          esc_nxt = 1'b1;
        end
        else
        begin
          wr_char = bchar;
          esc_nxt = 1'b0;
          src_nxt = src_r + 7'h01;
          if (src_r == blen - 7'h01)
            st_nxt = scp_pkg::ST_CR;
        end
      end
      scp_pkg::ST_CR:
      begin
        wr_en = 1'b1;
        wr_char = `SCP_CH_CR; // see RULE13
        st_nxt = scp_pkg::ST_LF;
      end
      scp_pkg::ST_LF:
      begin
        wr_en = 1'b1;
        wr_char = `SCP_CH_LF; // see RULE13
        len_nxt = dst_r + 7'h01;
        done_ev = 1'b1;
        st_nxt = scp_pkg::ST_IDLE;
      end
    endcase
    if (wr_en)
      dst_nxt = dst_r + 7'h01;
  end

  // builder registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= scp_pkg::ST_IDLE;
      kind_r <= scp_pkg::K_TYPE;
      snap_r <= '0;
      src_r <= 7'h00;
      dst_r <= 7'h00;
      rd_r <= 7'h00;
      len_r <= 7'h00;
      esc_r <= 1'b0;
      rst_r <= 1'b0;
      def_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      kind_r <= kind_nxt;
      snap_r <= snap_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      rd_r <= rd_nxt;
      len_r <= len_nxt;
      esc_r <= esc_nxt;
      rst_r <= rst_nxt;
      def_r <= def_nxt;
    end
  end

  // line memory
  always_ff @(posedge pclk)
  begin
    if (wr_en)
      resp_mem[dst_r] <= wr_char;
  end

  assign restart_req = rst_r; // see RULE4 RULE5
  assign drop_conns = rst_r; // see RULE4 RULE5
  assign restore_req = def_r; // see RULE5

  // ----------------------------------------------------------------
  // interrupts and read data
  // ----------------------------------------------------------------
  logic [`SCP_IRQ_W-1:0] ist_r, ist_nxt; // sticky status
  logic [`SCP_IRQ_W-1:0] ien_r, ien_nxt; // enables
  logic irq_r, irq_nxt; // interrupt level
  logic [31:0] prdata_r, prdata_nxt; // read data
  logic perr_r, perr_nxt; // unmapped address

  // status set wins over clear; read data taken in setup phase
  always_comb
  begin
    ist_nxt = ist_r;
    ien_nxt = ien_r;
    if (wr_acc && (paddr == `SCP_ADDR_IRQ_CLR))
      ist_nxt = ist_r & ~pwdata[`SCP_IRQ_W-1:0];
    if (wr_acc && (paddr == `SCP_ADDR_IRQ_EN))
      ien_nxt = pwdata[`SCP_IRQ_W-1:0];
    ist_nxt = ist_nxt | {busy_ev, trunc_ev, done_ev};
    irq_nxt = |(ist_nxt & ien_nxt);
    prdata_nxt = prdata_r;
    perr_nxt = perr_r;
    if (setup)
    begin
      perr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      case (paddr)
        `SCP_ADDR_CMD, `SCP_ADDR_LABEL_IN, `SCP_ADDR_IRQ_CLR: prdata_nxt = 32'h0000_0000;
        `SCP_ADDR_STATUS:
          prdata_nxt = {9'h000, rd_r, 1'b0, len_r, 6'h00, avail, st_r != scp_pkg::ST_IDLE};
        `SCP_ADDR_RESP: prdata_nxt = {23'h000000, avail, resp_mem[rd_r]};
        `SCP_ADDR_IRQ_STAT: prdata_nxt = {29'h00000000, ist_r};
        `SCP_ADDR_IRQ_EN: prdata_nxt = {29'h00000000, ien_r};
        `SCP_ADDR_LABEL_LEN: prdata_nxt = {25'h0000000, lbl_len_r};
        default: perr_nxt = 1'b1;
      endcase
    end
  end

  // interrupt and bus output registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ist_r <= '0;
      ien_r <= '0;
      irq_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      perr_r <= 1'b0;
    end
    else
    begin
      ist_r <= ist_nxt;
      ien_r <= ien_nxt;
      irq_r <= irq_nxt;
      prdata_r <= prdata_nxt;
      perr_r <= perr_nxt;
    end
  end

  assign irq = irq_r;
  assign prdata = prdata_r;
  assign pslverr = perr_r & psel & penable;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_type_readonly: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && st_r == scp_pkg::ST_IDLE && pwdata[3:0] == `SCP_CMD_SET_TYPE)
    |=> kind_r == scp_pkg::K_PERR) else $error("type name set not refused"); // see RULE1
  a_label_limit: assert property (@(posedge pclk) disable iff (!presetn)
    (lbl_len_r == `SCP_LABEL_MAX && lbl_we == 1'b0 && trunc_ev)
    |=> lbl_len_r == `SCP_LABEL_MAX) else $error("label grew past limit"); // see RULE2
  a_reset_silent: assert property (@(posedge pclk) disable iff (!presetn)
    (cmd_go && st_r == scp_pkg::ST_IDLE && pwdata[7:0] == {`SCP_RESET_ARG, `SCP_CMD_CALL_RESET})
    |=> restart_req && drop_conns && st_r == scp_pkg::ST_IDLE && !avail)
    else $error("reset call replied or did not restart"); // see RULE4
  a_defaults_all: assert property (@(posedge pclk) disable iff (!presetn)
    restore_req |-> restart_req && drop_conns ##1 lbl_len_r == 7'h00 && !avail)
    else $error("defaults call incomplete"); // see RULE5
  a_port_length: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == scp_pkg::ST_LF && kind_r == scp_pkg::K_PORTS) |-> dst_r == 7'h1b)
    else $error("port list length wrong"); // see RULE6
  a_zero_byte: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == scp_pkg::ST_BODY && kind_r == scp_pkg::K_PORTS && (pos == 1 || pos == 2))
    |-> wr_char == 8'h30) else $error("reserved byte not zero"); // see RULE9
  a_port_letter: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == scp_pkg::ST_BODY && kind_r == scp_pkg::K_PORTS && pos == 0 && !ps.muted && !ps.locked)
    |-> wr_char == 8'h54) else $error("unmuted unlocked letter wrong"); // see RULE8
  a_hex_low: assert property (@(posedge pclk) disable iff (!presetn)
    (st_r == scp_pkg::ST_BODY && kind_r == scp_pkg::K_PORTS && pos == 4 && ps.conn == 2'h3
     && ps.sig == 2'h3) |-> wr_char == 8'h46) else $error("low hex char wrong"); // see RULE10
  a_line_end: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == scp_pkg::ST_CR |-> wr_char == 8'h0d ##1 st_r == scp_pkg::ST_LF && wr_char == 8'h0a
    ##1 avail) else $error("line end wrong"); // see RULE13
  a_prefix_space: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(st_r == scp_pkg::ST_PFX) |-> ##2 wr_char == 8'h20)
    else $error("prefix not two characters"); // see RULE14
endmodule : scp_top

/* sim/scp_src_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------
// video input status source
// ----------------------------------------------------------------
module scp_src_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic load,
  input wire scp_pkg::scp_port_t [3:0] next_state,
  output scp_pkg::scp_port_t [3:0] port_state
);
  // status stays steady between loads, as a real input would between changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      port_state <= '0;
    end
    else if (load)
    begin
      port_state <= next_state;
    end
  end
endmodule : scp_src_model

/* sim/scp_top_tb_top.sv */
`timescale 1ns/100ps
`include "scp_params.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
  $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module scp_top_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, restart_req, restore_req, drop_conns, irq;
  logic load = 1'b0;
  scp_pkg::scp_port_t [3:0] next_state = '0;
  scp_pkg::scp_port_t [3:0] port_state;
  logic [32:0] exp_q[$]; // expected {pslverr, prdata}
  logic [32:0] msk_q[$]; // bits that matter
  logic [2:0] pulse_q[$]; // expected {restart, restore, drop}
  logic [7:0] lq[$]; // expected response line
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  logic [31:0] rng = 32'h0001524b;
  logic [31:0] rd;
  logic [31:0] rv; // one random draw
  logic [2:0] pexp; // expected pulse pattern
  string ltr = "TLMU"; // letter per {muted, locked}
  string lbl = "abcdefghijklmnopqrstuvwxyzABCDEFGHIJKLMNOP";
  always #2 pclk = ~pclk;
  // identity strings below are arbitrary
  scp_top #(.TYPE_NAME("TEST-UNIT-07"), .SERIAL_NUM("55667788"), .FW_VERSION("3.1.4c"))
  scp_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .port_state(port_state), .restart_req(restart_req),
    .restore_req(restore_req), .drop_conns(drop_conns), .irq(irq));
  scp_src_model scp_src_model_inst (.pclk(pclk), .presetn(presetn), .load(load),
    .next_state(next_state), .port_state(port_state));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : rnd
  // one nibble as upper case hex character
  function automatic logic [7:0] hexc(input logic [3:0] d);
    return (d < 4'ha) ? 8'h30 + {4'h0, d} : 8'h37 + {4'h0, d};
  endfunction : hexc
  // apb transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [32:0] m, input logic [32:0] e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    msk_q.push_back(m);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h1_0000_0000, 33'h0);
  endtask : wr
  task automatic rdx(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b1, m}, {1'b0, e});
  endtask : rdx
  // poll status until the builder is idle
  task automatic wait_idle();
    int k;
    k = 0;
    rd = 32'h1;
    while (rd[0] === 1'b1 && k < 300)
    begin
      rdx(`SCP_ADDR_STATUS, 32'h0, 32'h0);
      k++;
    end
  endtask : wait_idle
  task automatic cmd(input logic [3:0] code, input logic [3:0] arg);
    wr(`SCP_ADDR_CMD, {24'h0, arg, code});
    wait_idle();
  endtask : cmd
  task automatic add(input string s);
    foreach (s[i]) lq.push_back(s[i]);
  endtask : add
  // read the noted line, optional line end, then an empty response
  task automatic line(input bit full);
    foreach (lq[i]) rdx(`SCP_ADDR_RESP, 32'h1ff, {23'h0, 1'b1, lq[i]});
    lq.delete();
    if (full) rdx(`SCP_ADDR_RESP, 32'h1ff, 32'h10d);
    if (full) rdx(`SCP_ADDR_RESP, 32'h1ff, 32'h10a);
    rdx(`SCP_ADDR_RESP, 32'h100, 32'h0);
  endtask : line
  task automatic complete_run();
    $display("counts: %0d compared, %0d wrong", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // monitor: takes the oldest note whenever a result appears
  // ----------------------------------------------------------------
  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      bad_count++;
      complete_run();
    end
    if (psel && penable && pready && exp_q.size() > 0)
    begin
      if (msk_q[0] != 33'h0) `CHK({pslverr, prdata} & msk_q[0], exp_q[0] & msk_q[0])
      void'(exp_q.pop_front());
      void'(msk_q.pop_front());
    end
    // restart pulses only where a call asked for them
    if (restart_req || restore_req || drop_conns)
    begin
      pexp = (pulse_q.size() > 0) ? pulse_q.pop_front() : 3'b000;
      `CHK({restart_req, restore_req, drop_conns}, pexp)
    end
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdx(`SCP_ADDR_IRQ_STAT, 32'h7, 32'h0);
    rdx(`SCP_ADDR_IRQ_EN, 32'h7, 32'h0);
    rdx(`SCP_ADDR_LABEL_LEN, 32'h7f, 32'h0);
    apb(1'b0, 8'h20, 32'h0, 33'h1_0000_0000, 33'h1_0000_0000);
    apb(1'b1, 8'h24, 32'h5, 33'h1_0000_0000, 33'h1_0000_0000);
    $display("test reset values done");
    wr(`SCP_ADDR_IRQ_EN, 32'h7);
    cmd(`SCP_CMD_GET_TYPE, 4'h0);
    add("pr TEST-UNIT-07");
    line(1'b1);
    `CHK(irq, 1'b1)
    wr(`SCP_ADDR_IRQ_CLR, 32'h1);
    rdx(`SCP_ADDR_IRQ_STAT, 32'h1, 32'h0);
    `CHK(irq, 1'b0)
    cmd(`SCP_CMD_SET_TYPE, 4'h0);
    add("pE ");
    line(1'b1);
    cmd(`SCP_CMD_GET_TYPE, 4'h0);
    add("pr TEST-UNIT-07");
    line(1'b1);
    cmd(`SCP_CMD_GET_SERIAL, 4'h0);
    add("pr 55667788");
    line(1'b1);
    cmd(`SCP_CMD_GET_FW, 4'h0);
    add("pr 3.1.4c");
    line(1'b1);
    $display("test fixed properties done");
    // 41 characters plus one non-ascii byte in place of the 21st, kept to 39
    wr(`SCP_ADDR_LABEL_IN, 32'h100);
    foreach (lbl[i]) wr(`SCP_ADDR_LABEL_IN, (i == 20) ? 32'h80 : {24'h0, lbl[i]});
    rdx(`SCP_ADDR_LABEL_LEN, 32'h7f, 32'd39);
    rdx(`SCP_ADDR_IRQ_STAT, 32'h2, 32'h2);
    for (int c = 3; c <= 4; c++)
    begin
      cmd(4'(c), 4'h0);
      add({"pw ", lbl.substr(0, 19), lbl.substr(21, 39)});
      line(1'b1);
    end
    // escaped bracket kept literal, escaped again on echo
    wr(`SCP_ADDR_LABEL_IN, 32'h100);
    add("a\\(b");
    foreach (lq[i]) wr(`SCP_ADDR_LABEL_IN, {24'h0, lq[i]});
    lq.delete();
    rdx(`SCP_ADDR_LABEL_LEN, 32'h7f, 32'd3);
    cmd(`SCP_CMD_GET_LABEL, 4'h0);
    add("pw a\\(b");
    line(1'b1);
    $display("test label done");
    // each input gets its own letter, random fields
    repeat (3)
    begin
      @(posedge pclk);
      // input 0 always shows signal and cable present, low digit F
      for (int p = 0; p < 4; p++)
      begin
        rv = rnd();
        next_state[p] <= {2'(p), rv[7:0] | ((p == 0) ? 8'h0f : 8'h00)};
      end
      load <= 1'b1;
      @(posedge pclk);
      load <= 1'b0;
      cmd(`SCP_CMD_GET_PORTS, 4'h0);
      add("pr ");
      for (int p = 0; p < 4; p++)
      begin
        lq.push_back(ltr[p]);
        add("00");
        lq.push_back(hexc({next_state[p].audio, next_state[p].prot}));
        lq.push_back(hexc({next_state[p].sig, next_state[p].conn}));
        if (p < 3) add(";");
      end
      line(1'b1);
    end
    $display("test port list done");
    pulse_q.push_back(3'b101);
    cmd(`SCP_CMD_CALL_RESET, `SCP_RESET_ARG);
    line(1'b0);
    cmd(`SCP_CMD_CALL_RESET, 4'h2);
    add("mE ");
    line(1'b1);
    pulse_q.push_back(3'b111);
    cmd(`SCP_CMD_CALL_DEFAULTS, 4'h0);
    line(1'b0);
    rdx(`SCP_ADDR_LABEL_LEN, 32'h7f, 32'h0);
    `CHK(pulse_q.size(), 0)
    $display("test restart calls done");
    // second command while busy is dropped and flagged
    wr(`SCP_ADDR_IRQ_CLR, 32'h7);
    wr(`SCP_ADDR_CMD, {28'h0, `SCP_CMD_GET_FW});
    wr(`SCP_ADDR_CMD, {28'h0, `SCP_CMD_GET_SERIAL});
    wait_idle();
    rdx(`SCP_ADDR_IRQ_STAT, 32'h4, 32'h4);
    add("pr 3.1.4c");
    line(1'b1);
    cmd(4'hf, 4'h0);
    add("mE ");
    line(1'b1);
    wr(`SCP_ADDR_IRQ_EN, 32'h0);
    rdx(`SCP_ADDR_IRQ_STAT, 32'h5, 32'h5);
    `CHK(irq, 1'b0)
    $display("test busy and masking done");
    complete_run();
  end
endmodule : scp_top_tb_top
